// ### bench/acsc_core_tb.sv
// Bench of the serial command and mode block; it stands in for the ADC
// core and oscillator. Assumes acsc_pkg and the host model are compiled.
`timescale 1ns/1ps
module acsc_core_tb;
  import acsc_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic spiSclk, spiCsN, spiSdi, spiSdo, spiSdoOeN, convStart, resultReady, ok;
  logic resultValid, oscTick, sequenceRunning, statisticsEnable, crcEnable, brownoutFlag;
  logic [2:0] convChannel, resultChannel, c, p;
  logic [15:0] resultData, a, w;
  logic [1:0] clockModeSelect;
  acsc_mode_t functionalMode;
  logic [31:0] rx;
  logic [7:0] v, r, m;
  logic [15:0] q[$];
  int fails = 0;
  int num_checks = 0;
  int seed = 97;
  int starts = 0;
  int s, i, k;
  logic [1:0] cv[5] = '{CONV_MANUAL, CONV_MANUAL, CONV_MANUAL, CONV_AUTON, CONV_TURBO};
  logic [1:0] sq[5] = '{SEQM_MANUAL, SEQM_OTF, SEQM_AUTO, SEQM_AUTO, SEQM_AUTO};
  acsc_mode_t md[5] = '{MODE_MANUAL, MODE_OTF, MODE_AUTO, MODE_AUTON, MODE_TURBO};
  acsc_core u_acsc_core (.core_clk(core_clk), .arst_n(arst_n), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN),
    .convStart(convStart), .convChannel(convChannel), .resultValid(resultValid),
    .resultReady(resultReady), .resultData(resultData), .resultChannel(resultChannel),
    .oscTick(oscTick), .functionalMode(functionalMode), .sequenceRunning(sequenceRunning),
    .statisticsEnable(statisticsEnable), .crcEnable(crcEnable),
    .clockModeSelect(clockModeSelect), .brownoutFlag(brownoutFlag));
  acsc_host u_acsc_host (.sclk(spiSclk), .csN(spiCsN), .sdi(spiSdi), .sdo(spiSdo),
    .sdoOeN(spiSdoOeN));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (convStart === 1'b1) starts++;
  initial begin
    #900000;
    fails++;
    finish_test();
  end
  // ****
  // Helpers
  // ****
  task automatic finish_test();
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    u_acsc_host.xfer({OP_WRITE, ad, d, 8'h00}, (crcEnable === 1'b1) ? 32 : 24, rx);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    int n;
    n = (crcEnable === 1'b1) ? 32 : 24;
    u_acsc_host.xfer({OP_READ, ad, 16'h0000}, n, rx);
    u_acsc_host.xfer(32'h0, n, rx);
    d = rx[31:24];
  endtask : rd
  task automatic rs(input logic [7:0] base, output logic [15:0] d);
    rd(base + {4'h0, c, 1'b0}, d[7:0]);
    rd(base + {4'h0, c, 1'b1}, d[15:8]);
  endtask : rs
  // Holds valid and data until taken; gives up after four cycles
  task automatic push(input logic [15:0] d, input logic [2:0] ch, output logic taken);
    taken = 1'b0;
    @(negedge core_clk);
    resultValid = 1'b1;
    resultData = d;
    resultChannel = ch;
    for (int j = 0; j < 4 && !taken; j++) begin
      // Ready is settled here and holds until the rising edge that takes the word
      taken = (resultReady === 1'b1);
      @(negedge core_clk);
    end
    resultValid = 1'b0;
  endtask : push
  function automatic logic [7:0] crc8(input logic [7:0] x);
    logic [7:0] t;
    t = x;
    repeat (8) t = t[7] ? ({t[6:0], 1'b0} ^ CRC_POLY) : {t[6:0], 1'b0};
    return t;
  endfunction : crc8
  function automatic logic [2:0] nextCh(input logic [7:0] mk, input logic [2:0] cur);
    for (int j = 1; j <= 8; j++) if (mk[(cur + j) % 8]) return 3'((cur + j) % 8);
    return cur;
  endfunction : nextCh
  // ****
  // Scenarios
  // ****
  initial begin
    resultValid = 1'b0;
    resultData = '0;
    resultChannel = '0;
    oscTick = 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(functionalMode, MODE_MANUAL);
    chk(brownoutFlag, 1'b1);
    chk(clockModeSelect, CLK_MODE_RST);
    chk({statisticsEnable, crcEnable}, 2'h0);
    chk({spiSdoOeN, spiSdo}, 2'h2);
    p = 3'h0;
    for (i = 0; i < 4; i++) begin
      v = {5'h0, 3'($random(seed))};
      s = starts;
      wr(ADDR_MAN_CH, v);
      chk(convChannel, p);
      rd(ADDR_MAN_CH, r);
      chk(r, v);
      chk(convChannel, v);
      r = (i == 0) ? 8'h00 : {1'b1, 7'($random(seed))};
      u_acsc_host.xfer({r, ADDR_MAN_CH, ~v, 8'h00}, 24, rx);
      rd(ADDR_MAN_CH, r);
      chk(r, v);
      chk(starts - s, 6);
      p = v[2:0];
    end
    wr(ADDR_GEN_CFG, 8'h40);
    rd(ADDR_MAN_CH, r);
    chk(rx[23:0], {crc8(v), 16'h0});
    wr(ADDR_GEN_CFG, 8'h00);
    for (k = 0; k < 5; k++) begin
      q.push_back(16'($random(seed)) | 16'h0001);
      push(q[k], 3'h0, ok);
      chk(ok, k < 4);
    end
    void'(q.pop_back());
    u_acsc_host.slowNs = 400;
    u_acsc_host.xfer(32'h0, 24, rx);
    // First frame still carries what the previous frame end loaded
    chk(rx, 32'h0);
    u_acsc_host.xfer(32'h0, 24, rx);
    for (k = 0; k < 5; k++) begin
      chk(rx, {(k < 4) ? q[k] : 16'h0, 16'h0});
      u_acsc_host.xfer(32'h0, 24, rx);
    end
    u_acsc_host.slowNs = 0;
    c = 3'($random(seed));
    a = 16'($random(seed));
    wr(ADDR_GEN_CFG, 8'h20);
    chk(statisticsEnable, 1'b1);
    push(a, c, ok);
    push(~a, c, ok);
    rs(8'h60, w);
    chk(w, (a > ~a) ? a : 16'(~a));
    rs(8'h80, w);
    chk(w, (a < ~a) ? a : 16'(~a));
    wr(ADDR_GEN_CFG, 8'h00);
    push(a, c, ok);
    rs(8'hA0, w);
    chk(w, 16'(~a));
    wr(ADDR_GEN_CFG, 8'h20);
    push(a, c, ok);
    wr(ADDR_GEN_CFG, 8'h20);
    rs(8'h60, w);
    chk(w, STAT_MAX_RST);
    rs(8'h80, w);
    chk(w, STAT_MIN_RST);
    for (i = 1; i < 4; i++) begin
      wr(ADDR_DATA_CFG, 8'(i));
      u_acsc_host.mode = 2'(i);
      chk(clockModeSelect, i);
      rd(ADDR_DATA_CFG, r);
      chk(r, i);
    end
    wr(ADDR_SYS_STATUS, 8'h01);
    chk(brownoutFlag, 1'b0);
    wr(ADDR_GEN_CFG, 8'h01);
    u_acsc_host.mode = 2'h0;
    chk(brownoutFlag, 1'b1);
    chk(clockModeSelect, CLK_MODE_RST);
    rd(ADDR_MAN_CH, r);
    chk(r, 8'h00);
    for (i = 0; i < 5; i++) begin
      wr(ADDR_OPMODE_CFG, {1'b0, cv[i], 5'h00});
      wr(ADDR_SEQ_CFG, {6'h00, sq[i]});
      chk(functionalMode, md[i]);
      if (i == 1) begin
        v = 8'($random(seed));
        u_acsc_host.xfer({v[4:0], 27'h0}, 24, rx);
        chk(convChannel, v[2:0]);
      end
    end
    for (i = 2; i < 5; i++) begin
      m = 8'($random(seed));
      if (m == 8'h00) m = 8'h81;
      wr(ADDR_SEQ_CFG, 8'h00);
      wr(ADDR_OPMODE_CFG, {1'b0, cv[i], 5'h00});
      wr(ADDR_SEQ_MASK, m);
      wr(ADDR_SEQ_CFG, {6'h04, sq[i]});
      chk(sequenceRunning, 1'b1);
      push(16'h5A5A, 3'h0, ok);
      u_acsc_host.xfer(32'h0, 24, rx);
      if (i > 2) begin
        chk(rx, 32'h0);
        // A result wrongly queued in self mode would show in this frame
        u_acsc_host.xfer(32'h0, 24, rx);
        chk(rx, 32'h0);
      end
      for (k = 0; k < 9; k++) begin
        p = convChannel;
        s = starts;
        if (i == 2) u_acsc_host.xfer(32'h0, 24, rx);
        else begin
          @(negedge core_clk) oscTick = 1'b1;
          @(negedge core_clk) oscTick = 1'b0;
          repeat (2) @(negedge core_clk);
        end
        chk(starts - s, 1);
        chk(convChannel, nextCh(m, p));
      end
    end
    finish_test();
  end
endmodule : acsc_core_tb

// ### bench/acsc_host.sv
// Host model of the serial link: frames of up to 32 bits in any clock mode.
// Assumes the bench sets mode before a frame and calls xfer.
`timescale 1ns/1ps
module acsc_host (
  output logic sclk,
  output logic csN,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoOeN
);
  logic [1:0] mode = 2'h0;
  int slowNs = 0;
  logic lastSdo = 1'b0;
  // Released pin reads as the inverse of its last level, never a stale copy
  always @(sdo or sdoOeN) if (!sdoOeN) lastSdo = sdo;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end
  // ****
  // One frame, MSB first
  // ****
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    sclk = mode[1];
    #20;
    csN = 1'b0;
    #100;
    for (int i = 31; i > 31 - n; i--) begin
      if (mode[0]) sclk = ~sclk;
      sdi = tx[i];
      #62.5;
      sclk = ~sclk;
      rx[i] = sdoOeN ? ~lastSdo : sdo;
      #62.5;
      if (!mode[0]) sclk = ~sclk;
    end
    #(62 + slowNs);
    csN = 1'b1;
    sdi = ~sdi;
    #(100 + slowNs);
  endtask : xfer
endmodule : acsc_host

// ### include/acsc_pkg.sv
// Constants, codes and types of the ADC serial command and mode block.
// Assumes users import the whole package.
package acsc_pkg;
  // ********************
  // Frames and opcodes
  // ********************
  localparam int FRAME_BITS = 24;
  localparam int TX_BITS = 32;
  localparam int OTF_LAST_BIT = 4;
  localparam int STAT_W = 16;
  localparam logic [7:0] OP_WRITE = 8'h08;
  localparam logic [7:0] OP_READ = 8'h10;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // ********************
  // Register addresses
  // ********************
  localparam logic [7:0] ADDR_SYS_STATUS = 8'h00;
  localparam logic [7:0] ADDR_GEN_CFG = 8'h01;
  localparam logic [7:0] ADDR_DATA_CFG = 8'h02;
  localparam logic [7:0] ADDR_OPMODE_CFG = 8'h04;
  localparam logic [7:0] ADDR_SEQ_CFG = 8'h10;
  localparam logic [7:0] ADDR_MAN_CH = 8'h11;
  localparam logic [7:0] ADDR_SEQ_MASK = 8'h12;
  localparam logic [2:0] PAGE_MAX = 3'h3;
  localparam logic [2:0] PAGE_MIN = 3'h4;
  localparam logic [2:0] PAGE_RECENT = 3'h5;
  // ********************
  // Field positions
  // ********************
  localparam int GEN_CRC_BIT = 6;
  localparam int GEN_STAT_BIT = 5;
  localparam int GEN_RST_BIT = 0;
  localparam int SYS_RSVD_BIT = 7;
  localparam int SYS_SEQ_BIT = 6;
  localparam int SYS_BROWN_BIT = 0;
  localparam int OPM_CONV_LSB = 5;
  localparam int SEQUENCE_START_BIT = 4;
  localparam int SEQUENCER_MODE_FIELD_LSB = 0;
  // ********************
  // Reset values and mode codes
  // ********************
  localparam logic [7:0] GEN_CFG_RST = 8'h00;
  localparam logic [7:0] GEN_CFG_MASK = 8'h76;
  localparam logic [1:0] CLK_MODE_RST = 2'h0;
  localparam logic [1:0] CONV_MANUAL = 2'h0;
  localparam logic [1:0] CONV_AUTON = 2'h1;
  localparam logic [1:0] CONV_TURBO = 2'h2;
  localparam logic [1:0] SEQM_MANUAL = 2'h0;
  localparam logic [1:0] SEQM_AUTO = 2'h1;
  localparam logic [1:0] SEQM_OTF = 2'h2;
  localparam logic [STAT_W-1:0] STAT_MIN_RST = 16'hFFFF;
  localparam logic [STAT_W-1:0] STAT_MAX_RST = 16'h0000;
  typedef enum logic [4:0] {
    MODE_MANUAL = 5'b00001,
    MODE_OTF = 5'b00010,
    MODE_AUTO = 5'b00100,
    MODE_AUTON = 5'b01000,
    MODE_TURBO = 5'b10000
  } acsc_mode_t;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_FRAME = 2'b10
  } acsc_link_t;
endpackage : acsc_pkg

// ### rtl/acsc_core.sv
// Serial command decoder, mode control, sequencer and statistics of an
// 8-channel ADC front end.
// Assumes the ADC core takes convStart/convChannel and returns results
// through resultValid/resultReady; oscTick is a one-cycle core_clk pulse.
`timescale 1ns/1ps
// Summary of operation
// - Writing statistics enable one restarts recording
// - Stored statistics held until next result
// - Statistics frozen while enable is zero
// - Four clock modes, edge chosen per frame
// - Reset selects idle low, rising capture
// - Write frame: opcode, address, data
// - Write decoded and applied at select rise
// - Read frame: opcode, address, dummy byte
// - Register byte leads the following frame
// - CRC byte follows register byte when enabled
// - Mode from two fields, manual at reset
// - Brownout flag at power-up; soft reset
// - Manual channel change lands one frame later
// - On-the-fly channel from first five bits
// - Sequencer steps ascending while start set in AUTO, AUTON or TURBO mode
// - Sequencer wraps to lowest enabled channel
// - Host gives first start, oscillator rest
// - Autonomous mode sends no conversion data
// - Turbo mode: no data, sequencer steps
// - Statistics enable at configuration bit five
module acsc_core #(
  parameter int CHANNELS = 8,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiSdi,
  output logic spiSdo,
  output logic spiSdoOeN,
  output logic convStart,
  output logic [$clog2(CHANNELS)-1:0] convChannel,
  input wire logic resultValid,
  output logic resultReady,
  input wire logic [acsc_pkg::STAT_W-1:0] resultData,
  input wire logic [$clog2(CHANNELS)-1:0] resultChannel,
  input wire logic oscTick,
  output acsc_pkg::acsc_mode_t functionalMode,
  output logic sequenceRunning,
  output logic statisticsEnable,
  output logic crcEnable,
  output logic [1:0] clockModeSelect,
  output logic brownoutFlag
);
  import acsc_pkg::*;
  localparam int CW = $clog2(CHANNELS);

  // ********************
  // Pin sampling and edges
  // ********************
  logic [2:0] pinS;
  logic sclkD_r;
  logic csnD_r;
  acsc_pin_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn({spiSdi, spiCsN, spiSclk}),
    .pinOut(pinS)
  );
  wire sclkS = pinS[0];
  wire csnS = pinS[1];
  wire sdiS = pinS[2];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkD_r <= 1'b0;
      csnD_r <= 1'b1;
    end else begin
      sclkD_r <= sclkS;
      csnD_r <= csnS;
    end
  end
  wire csFall = csnD_r & ~csnS;
  wire csRise = ~csnD_r & csnS;
  wire sclkRise = sclkS & ~sclkD_r;
  wire sclkFall = ~sclkS & sclkD_r;

  // ********************
  // Frame engine
  // ********************
  acsc_link_t linkState_r;
  logic [1:0] frameMode_r;
  logic [5:0] bitCnt_r;
  logic [FRAME_BITS-1:0] rxShift_r;
  logic [TX_BITS-1:0] txShift_r;
  logic [CW-1:0] otfCh_r;
  wire inFrame = (linkState_r == LINK_FRAME);
  wire captureOnRise = (frameMode_r == 2'h0) | (frameMode_r == 2'h3);
  wire captureEdge = inFrame & (captureOnRise ? sclkRise : sclkFall);
  // No launch before the first capture keeps the MSB for phase-one modes
  wire launchEdge = inFrame & (captureOnRise ? sclkFall : sclkRise) & (bitCnt_r != '0);
  wire frameFull = bitCnt_r >= 6'(FRAME_BITS);
  wire frameEnd = csRise & inFrame;
  wire [7:0] rxCmd = rxShift_r[23:16];
  wire [7:0] rxAddr = rxShift_r[15:8];
  wire [7:0] rxData = rxShift_r[7:0];
  wire doWrite = frameEnd & frameFull & (rxCmd == OP_WRITE);
  wire doRead = frameEnd & frameFull & (rxCmd == OP_READ);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkState_r <= LINK_IDLE;
    end else begin
      case (linkState_r)
        LINK_IDLE: if (csFall) linkState_r <= LINK_FRAME;
        LINK_FRAME: if (csRise) linkState_r <= LINK_IDLE;
        default: linkState_r <= LINK_IDLE;
      endcase
    end
  end

  logic [1:0] clkMode_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameMode_r <= CLK_MODE_RST;
      bitCnt_r <= '0;
      rxShift_r <= '0;
      otfCh_r <= '0;
    end else if (csFall) begin
      frameMode_r <= clkMode_r;
      bitCnt_r <= '0;
    end else if (captureEdge) begin
      if (bitCnt_r != 6'(TX_BITS)) bitCnt_r <= bitCnt_r + 6'h01;
      if (!frameFull) rxShift_r <= {rxShift_r[FRAME_BITS-2:0], sdiS};
      if (bitCnt_r == 6'(OTF_LAST_BIT)) otfCh_r <= {rxShift_r[CW-2:0], sdiS};
    end
  end

  // ********************
  // Configuration state
  // ********************
  logic [7:0] genCfg_r;
  logic [1:0] convMode_r;
  logic [1:0] seqMode_r;
  logic seqStart_r;
  logic [3:0] manCh_r;
  logic [CHANNELS-1:0] seqMask_r;
  logic brown_r;
  wire wrSys = doWrite & (rxAddr == ADDR_SYS_STATUS);
  wire wrGen = doWrite & (rxAddr == ADDR_GEN_CFG);
  wire softRst = wrGen & rxData[GEN_RST_BIT];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      genCfg_r <= GEN_CFG_RST;
      clkMode_r <= CLK_MODE_RST;
      convMode_r <= CONV_MANUAL;
      seqMode_r <= SEQM_MANUAL;
      seqStart_r <= 1'b0;
      manCh_r <= '0;
      seqMask_r <= '0;
      brown_r <= 1'b1;
    end else if (softRst) begin
      genCfg_r <= GEN_CFG_RST;
      clkMode_r <= CLK_MODE_RST;
      convMode_r <= CONV_MANUAL;
      seqMode_r <= SEQM_MANUAL;
      seqStart_r <= 1'b0;
      manCh_r <= '0;
      seqMask_r <= '0;
      brown_r <= 1'b1;
    end else begin
      if (wrGen) genCfg_r <= rxData & GEN_CFG_MASK;
      if (doWrite && rxAddr == ADDR_DATA_CFG) clkMode_r <= rxData[1:0];
      if (doWrite && rxAddr == ADDR_OPMODE_CFG) convMode_r <= rxData[OPM_CONV_LSB +: 2];
      if (doWrite && rxAddr == ADDR_SEQ_CFG) begin
        seqMode_r <= rxData[SEQUENCER_MODE_FIELD_LSB +: 2];
        seqStart_r <= rxData[SEQUENCE_START_BIT];
      end
      if (doWrite && rxAddr == ADDR_MAN_CH) manCh_r <= rxData[3:0];
      if (doWrite && rxAddr == ADDR_SEQ_MASK) seqMask_r <= rxData[CHANNELS-1:0];
      if (wrSys && rxData[SYS_BROWN_BIT]) brown_r <= 1'b0;
    end
  end

  // ********************
  // Functional mode and sequencer
  // ********************
  acsc_mode_t modeNow;
  assign modeNow = (convMode_r == CONV_MANUAL && seqMode_r == SEQM_OTF) ? MODE_OTF :
                   (convMode_r == CONV_MANUAL && seqMode_r == SEQM_AUTO) ? MODE_AUTO :
                   (convMode_r == CONV_AUTON && seqMode_r == SEQM_AUTO) ? MODE_AUTON :
                   (convMode_r == CONV_TURBO && seqMode_r == SEQM_AUTO) ? MODE_TURBO :
                   MODE_MANUAL;
  wire hostStart = (modeNow == MODE_MANUAL) | (modeNow == MODE_OTF) | (modeNow == MODE_AUTO);
  wire selfStart = (modeNow == MODE_AUTON) | (modeNow == MODE_TURBO);
  wire seqActive = seqStart_r & ~(modeNow == MODE_MANUAL) & ~(modeNow == MODE_OTF);

  function automatic logic [CW-1:0] nextCh(input logic [CW-1:0] cur,
                                           input logic [CHANNELS-1:0] mask);
    logic [CW-1:0] res;
    logic found;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= CHANNELS; i++) begin
      if (!found && mask[(int'(cur) + i) % CHANNELS]) begin
        res = CW'((int'(cur) + i) % CHANNELS);
        found = 1'b1;
      end
    end
    return res;
  endfunction : nextCh

  logic [CW-1:0] seqCh_r;
  logic autonArmed_r;
  wire hostFirst = frameEnd & selfStart & seqActive & ~autonArmed_r;
  wire oscStart = oscTick & selfStart & seqActive & autonArmed_r;
  wire convStartNow = (frameEnd & hostStart) | hostFirst | oscStart;
  wire [CW-1:0] startCh = (modeNow == MODE_MANUAL) ? manCh_r[CW-1:0] :
                          (modeNow == MODE_OTF) ? otfCh_r : seqCh_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seqCh_r <= '0;
      autonArmed_r <= 1'b0;
      convStart <= 1'b0;
      convChannel <= '0;
    end else begin
      convStart <= convStartNow;
      if (convStartNow) convChannel <= startCh;
      // Parked on the lowest enabled channel until the sequencer runs
      if (!seqActive) seqCh_r <= nextCh(CW'(CHANNELS - 1), seqMask_r);
      else if (convStartNow) seqCh_r <= nextCh(seqCh_r, seqMask_r);
      if (!seqActive || !selfStart) autonArmed_r <= 1'b0;
      else if (hostFirst) autonArmed_r <= 1'b1;
    end
  end

  // ********************
  // Result path and statistics
  // ********************
  logic fifoInReady;
  logic fifoOutValid;
  logic [STAT_W-1:0] fifoOutData;
  logic popNow;
  wire fifoInValid = resultValid & hostStart;
  assign resultReady = hostStart ? fifoInReady : 1'b1;
  acsc_fifo #(.WIDTH(STAT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(resultData),
    .outValid(fifoOutValid),
    .outReady(popNow),
    .outData(fifoOutData)
  );

  logic [CHANNELS-1:0][STAT_W-1:0] statMin_r;
  logic [CHANNELS-1:0][STAT_W-1:0] statMax_r;
  logic [CHANNELS-1:0][STAT_W-1:0] statRecent_r;
  wire statClr = softRst | (wrGen & rxData[GEN_STAT_BIT]);
  wire statUpd = resultValid & resultReady & genCfg_r[GEN_STAT_BIT];

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_stat
      wire hit = statUpd & (resultChannel == CW'(c));
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          statMin_r[c] <= STAT_MIN_RST;
          statMax_r[c] <= STAT_MAX_RST;
          statRecent_r[c] <= STAT_MAX_RST;
        end else if (statClr) begin
          statMin_r[c] <= STAT_MIN_RST;
          statMax_r[c] <= STAT_MAX_RST;
          statRecent_r[c] <= STAT_MAX_RST;
        end else if (hit) begin
          statRecent_r[c] <= resultData;
          if (resultData < statMin_r[c]) statMin_r[c] <= resultData;
          if (resultData > statMax_r[c]) statMax_r[c] <= resultData;
        end
      end
    end
  endgenerate

  // ********************
  // Read data and serial output
  // ********************
  function automatic logic [7:0] crc8(input logic [7:0] val);
    logic [7:0] c;
    c = val;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  wire crcEn = genCfg_r[GEN_CRC_BIT];
  wire [2:0] rdPage = rxAddr[7:5];
  wire [CW-1:0] rdCh = rxAddr[CW:1];
  wire statHit = ~rxAddr[4] & (rdPage >= PAGE_MAX) & (rdPage <= PAGE_RECENT);
  wire [STAT_W-1:0] statWord = (rdPage == PAGE_MAX) ? statMax_r[rdCh] :
                               (rdPage == PAGE_MIN) ? statMin_r[rdCh] : statRecent_r[rdCh];
  wire [7:0] statByte = rxAddr[0] ? statWord[15:8] : statWord[7:0];
  wire [7:0] sysStatus = (8'h01 << SYS_RSVD_BIT) | (8'(seqActive) << SYS_SEQ_BIT) |
                         (8'(brown_r) << SYS_BROWN_BIT);
  logic [7:0] regByte;
  always_comb begin
    regByte = statHit ? statByte : 8'h00;
    case (rxAddr)
      ADDR_SYS_STATUS: regByte = sysStatus;
      ADDR_GEN_CFG: regByte = genCfg_r;
      ADDR_DATA_CFG: regByte = {6'h00, clkMode_r};
      ADDR_OPMODE_CFG: regByte = 8'(convMode_r) << OPM_CONV_LSB;
      ADDR_SEQ_CFG: regByte = (8'(seqStart_r) << SEQUENCE_START_BIT) | 8'(seqMode_r);
      ADDR_MAN_CH: regByte = {4'h0, manCh_r};
      ADDR_SEQ_MASK: regByte = 8'(seqMask_r);
      default: ;
    endcase
  end

  // A read answer keeps queued results for the frame after it
  assign popNow = frameEnd & ~doRead & hostStart & fifoOutValid;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift_r <= '0;
    end else if (frameEnd) begin
      if (doRead) txShift_r <= {regByte, crcEn ? crc8(regByte) : 8'h00, 16'h0000};
      else if (popNow) txShift_r <= {fifoOutData, 16'h0000};
      else txShift_r <= '0;
    end else if (launchEdge) begin
      txShift_r <= {txShift_r[TX_BITS-2:0], 1'b0};
    end
  end
  assign spiSdo = txShift_r[TX_BITS-1];
  assign spiSdoOeN = csnS;
  assign functionalMode = modeNow;
  assign sequenceRunning = seqActive;
  assign statisticsEnable = genCfg_r[GEN_STAT_BIT];
  assign crcEnable = crcEn;
  assign clockModeSelect = clkMode_r;
  assign brownoutFlag = brown_r;

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence sCmdEnd(logic [7:0] op);
    frameEnd && frameFull && rxCmd == op;
  endsequence
  chk_stat_restart: assert property (wrGen && rxData[GEN_STAT_BIT] |=>
    statMax_r == '0 && statRecent_r == '0 && statMin_r == '1) else $error("stat restart");
  chk_stat_update: assert property (statUpd && !statClr |=>
    statRecent_r[$past(resultChannel)] == $past(resultData)) else $error("stat update");
  chk_stat_frozen: assert property (!genCfg_r[GEN_STAT_BIT] && !statClr |=>
    $stable(statRecent_r) && $stable(statMax_r) && $stable(statMin_r)) else $error("stat moved");
  chk_frame_mode: assert property (csFall |=> frameMode_r == $past(clkMode_r))
    else $error("frame mode");
  chk_mode_default: assert property (softRst |=>
    clkMode_r == CLK_MODE_RST && modeNow == MODE_MANUAL && brown_r) else $error("soft reset");
  chk_write_apply: assert property (sCmdEnd(OP_WRITE) ##0 rxAddr == ADDR_MAN_CH |=>
    manCh_r == $past(rxData[3:0])) else $error("write lost");
  chk_read_byte: assert property (sCmdEnd(OP_READ) |=>
    txShift_r[31:24] == $past(regByte)) else $error("read byte");
  chk_read_crc: assert property (sCmdEnd(OP_READ) ##0 crcEn |=>
    txShift_r[23:16] == crc8($past(regByte))) else $error("read crc");
  chk_nop_frame: assert property (frameEnd && !doWrite |=>
    $stable(genCfg_r) && $stable(manCh_r) && $stable(seqMask_r)) else $error("nop wrote");
  chk_host_start: assert property (frameEnd && hostStart |=>
    convStart && convChannel == $past(startCh)) else $error("no start");
  chk_seq_step: assert property (convStartNow && seqActive |=>
    seqCh_r == nextCh($past(seqCh_r), $past(seqMask_r))) else $error("seq step");
  chk_self_quiet: assert property (selfStart && frameEnd && !doRead |=>
    txShift_r == '0) else $error("data in self mode");
  chk_self_gate: assert property (
    selfStart && !frameEnd && !(oscTick && autonArmed_r) |=> !convStart)
    else $error("start without seq");
endmodule : acsc_core

// ### rtl/acsc_fifo.sv
// Word FIFO on flip-flops with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module acsc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [DEPTH-1:0][WIDTH-1:0] mem_r;
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= bump(wrPtr_r);
      if (pop) rdPtr_r <= bump(rdPtr_r);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Data store needs no reset; outValid guards it
  always_ff @(posedge core_clk) begin
    if (push) mem_r[wrPtr_r] <= inData;
  end
endmodule : acsc_fifo

// ### rtl/acsc_pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module acsc_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RST_VAL;
      pinOut <= RST_VAL;
    end else begin
      meta_r <= pinIn;
      pinOut <= meta_r;
    end
  end
endmodule : acsc_pin_sync
